// ==== pic_pkg.sv ====
// Purpose: shared constants for the prioritized interrupt classifier
// Assumes: one clock, active-low asynchronous reset
// Notes: source count is a plain default, no per-source numbering implied
package pic_pkg;
   localparam int PIC_NSRC = 32;
   localparam int PIC_SRC_W = 5;
   localparam int PIC_NSLOT = 16;
   localparam int PIC_SLOT_W = 4;
   localparam int PIC_ADDR_W = 32;
   localparam logic [PIC_NSRC-1:0] PIC_SRC_ZERO = 32'h00000000;
   localparam logic [PIC_NSLOT-1:0] PIC_SLOT_ZERO = 16'h0000;
   localparam logic [PIC_ADDR_W-1:0] PIC_ADDR_ZERO = 32'h00000000;
   localparam logic [PIC_SRC_W-1:0] PIC_SRC_IDX_ZERO = 5'h00;
   localparam logic [PIC_SLOT_W-1:0] PIC_SLOT_IDX_ZERO = 4'h0;
endpackage : pic_pkg

// ==== pic_slot_sel.sv ====
// Purpose: per-slot request gather and fixed-priority slot pick
// Assumes: slot 0 highest, slot 15 lowest
// Notes: purely combinational
`timescale 1ns/100ps
module pic_slot_sel
   import pic_pkg::*;
(
   // inputs
   input wire logic [PIC_NSRC-1:0] req,
   input wire logic [PIC_NSLOT-1:0] slot_en,
   input wire logic [PIC_NSLOT*PIC_SRC_W-1:0] slot_src,
   // outputs
   output logic [PIC_NSLOT-1:0] slot_act,
   output logic any_act,
   output logic [PIC_SLOT_W-1:0] win
);
   genvar g;
   generate
      for (g = 0; g < PIC_NSLOT; g++) begin : g_slot
         assign slot_act[g] = slot_en[g] & req[slot_src[g*PIC_SRC_W +: PIC_SRC_W]];
      end
   endgenerate

   always_comb begin
      any_act = |slot_act;
      win = PIC_SLOT_IDX_ZERO;
      for (int i = PIC_NSLOT - 1; i >= 0; i--) begin
         if (slot_act[i]) begin
            win = PIC_SLOT_W'(i);
         end
      end
   end
endmodule : pic_slot_sel

// ==== pic_core.sv ====
// Purpose: classify level requests into fast, vectored and default classes
// Assumes: requests are level signals from logic on clk
// Notes: configuration inputs come from same-clock logic
//
// Overview of operation
// - each enabled request lands in exactly one class
// - fast class outranks all normal classes
// - all fast requests merge into one output
// - word shows which fast sources request
// - vectored ranks between fast and non-vectored
// - sixteen slots, any source to any slot
// - slot 0 highest, slot 15 lowest
// - classes and slots change at run time
// - non-vectored requests rank lowest
// - vectored and non-vectored merge into normal output
// - vector word gives winning slot address
// - otherwise vector word gives default address
`timescale 1ns/100ps
module pic_core
   import pic_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // requests
   input wire logic [PIC_NSRC-1:0] req,
   // configuration
   input wire logic [PIC_NSRC-1:0] src_en,
   input wire logic [PIC_NSRC-1:0] fast_sel,
   input wire logic [PIC_NSLOT-1:0] slot_en,
   input wire logic [PIC_NSLOT*PIC_SRC_W-1:0] slot_src,
   input wire logic [PIC_NSLOT*PIC_ADDR_W-1:0] slot_addr,
   input wire logic [PIC_ADDR_W-1:0] default_addr,
   // processor side
   output logic fast_request,
   output logic normal_request,
   output logic [PIC_NSRC-1:0] fast_status,
   output logic [PIC_NSRC-1:0] normal_status,
   output logic [PIC_ADDR_W-1:0] vector_addr,
   output logic vector_valid
);
   // ----------------------------------------
   // classification
   // ----------------------------------------
   logic [PIC_NSRC-1:0] live;
   logic [PIC_NSRC-1:0] in_slot;
   logic [PIC_NSRC-1:0] next_fast;
   logic [PIC_NSRC-1:0] next_normal;
   logic [PIC_NSLOT-1:0] slot_act;
   logic any_vec;
   logic [PIC_SLOT_W-1:0] win;
   logic [PIC_NSRC-1:0] vec_live;
   logic [PIC_NSRC-1:0] plain_live;
   logic [PIC_NSLOT-1:0] lower_act;

   assign live = req & src_en;

   always_comb begin
      in_slot = PIC_SRC_ZERO;
      for (int s = 0; s < PIC_NSLOT; s++) begin
         if (slot_en[s]) begin
            in_slot[slot_src[s*PIC_SRC_W +: PIC_SRC_W]] = 1'b1;
         end
      end
   end

   // fast selection wins over slot membership, so a source has one class
   assign next_fast = live & fast_sel;
   assign next_normal = live & ~fast_sel;
   assign vec_live = live & ~fast_sel;
   assign plain_live = vec_live & ~in_slot;

   pic_slot_sel u_sel (
      .req(vec_live),
      .slot_en(slot_en),
      .slot_src(slot_src),
      .slot_act(slot_act),
      .any_act(any_vec),
      .win(win)
   );

   // ----------------------------------------
   // registered outputs
   // ----------------------------------------
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         fast_request <= 1'b0;
         fast_status <= PIC_SRC_ZERO;
      end else begin
         fast_request <= |next_fast;
         fast_status <= next_fast;
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         normal_request <= 1'b0;
         normal_status <= PIC_SRC_ZERO;
      end else begin
         normal_request <= |next_normal;
         normal_status <= next_normal;
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         vector_addr <= PIC_ADDR_ZERO;
         vector_valid <= 1'b0;
      end else begin
         vector_valid <= any_vec;
         if (any_vec) begin
            // slot and address inputs are read every cycle, so a retune shows next cycle
            vector_addr <= slot_addr[win*PIC_ADDR_W +: PIC_ADDR_W];
         end else begin
            vector_addr <= default_addr;
         end
      end
   end

   // ----------------------------------------
   // check helpers
   // ----------------------------------------
   // lower_act[s] is high while some slot below s is active; built apart
   // from the picker loop so the rank check does not copy it
   genvar g;
   generate
      for (g = 0; g < PIC_NSLOT; g++) begin : g_rank
         if (g == 0) begin : g_first
            assign lower_act[g] = 1'b0;
         end else begin : g_rest
            assign lower_act[g] = lower_act[g-1] | slot_act[g-1];
         end
         AST_SLOT_ANY: assert property (@(posedge clk) disable iff (!rst_b)
            slot_en[g] && vec_live[slot_src[g*PIC_SRC_W +: PIC_SRC_W]] |=> vector_valid)
            else $error("slot source not seen");
         AST_SLOT_RANK: assert property (@(posedge clk) disable iff (!rst_b)
            slot_act[g] && !lower_act[g]
               |=> vector_addr == $past(slot_addr[g*PIC_ADDR_W +: PIC_ADDR_W]))
            else $error("slot lost to a lower ranked slot");
      end
   endgenerate

   // antecedents shared by the checks below
   sequence fast_seen;
      |(req & src_en & fast_sel);
   endsequence

   sequence fast_in_slot;
      |(live & fast_sel & in_slot);
   endsequence

   sequence plain_seen;
      |plain_live;
   endsequence

   sequence mixed_normal;
      any_vec && (|plain_live);
   endsequence

   // ----------------------------------------
   // checks: fast class
   // ----------------------------------------
   // a source picked as fast and also named by a slot must stay fast only
   AST_FAST_MERGE: assert property (@(posedge clk) disable iff (!rst_b)
      fast_seen |=> fast_request)
      else $error("fast request not raised");

   AST_FAST_DROP: assert property (@(posedge clk) disable iff (!rst_b)
      !(|(req & src_en & fast_sel)) |=> !fast_request)
      else $error("fast request stuck");

   AST_FAST_WORD: assert property (@(posedge clk) disable iff (!rst_b)
      1'b1 |=> fast_status == $past(req & src_en & fast_sel))
      else $error("fast word wrong");

   AST_FAST_OVER_SLOT: assert property (@(posedge clk) disable iff (!rst_b)
      fast_in_slot |=> fast_request
         && (normal_status & $past(live & fast_sel & in_slot)) == PIC_SRC_ZERO)
      else $error("slotted fast source left the fast class");

   AST_ONE_CLASS: assert property (@(posedge clk) disable iff (!rst_b)
      1'b1 |=> (fast_status & normal_status) == PIC_SRC_ZERO
         && (fast_status | normal_status) == $past(req & src_en))
      else $error("source not in exactly one class");

   // ----------------------------------------
   // checks: normal class
   // ----------------------------------------
   // enabled non-fast sources outside every slot fall back to the default routine
   AST_NORMAL_MERGE: assert property (@(posedge clk) disable iff (!rst_b)
      |(req & src_en & ~fast_sel) |=> normal_request)
      else $error("normal request not raised");

   AST_NORMAL_DROP: assert property (@(posedge clk) disable iff (!rst_b)
      !(|(req & src_en & ~fast_sel)) |=> !normal_request)
      else $error("normal request stuck");

   AST_UNASSIGNED: assert property (@(posedge clk) disable iff (!rst_b)
      plain_seen |=> normal_request
         && (normal_status & $past(plain_live)) == $past(plain_live))
      else $error("unassigned source lost");

   AST_VEC_OVER_PLAIN: assert property (@(posedge clk) disable iff (!rst_b)
      mixed_normal |=> vector_valid && normal_request)
      else $error("vectored request ranked below non-vectored");

   // ----------------------------------------
   // checks: vector word
   // ----------------------------------------
   // the address word follows the previous edge's inputs
   AST_DEFAULT_ADDR: assert property (@(posedge clk) disable iff (!rst_b)
      !any_vec |=> vector_addr == $past(default_addr) && !vector_valid)
      else $error("default address wrong");

   AST_PLAIN_LOWEST: assert property (@(posedge clk) disable iff (!rst_b)
      (|plain_live) && !any_vec |=> normal_request && !vector_valid)
      else $error("non-vectored request flagged as vectored");

   AST_SLOT0_WINS: assert property (@(posedge clk) disable iff (!rst_b)
      slot_act[0] |=> vector_addr == $past(slot_addr[PIC_ADDR_W-1:0]))
      else $error("slot 0 did not win");

   AST_VEC_VALID: assert property (@(posedge clk) disable iff (!rst_b)
      any_vec |=> vector_valid)
      else $error("vectored request not flagged");
endmodule : pic_core

// ==== pic_cpu_model.sv ====
// Purpose: processor stand-in that takes fast and normal requests
// Assumes: level requests on clk
// Notes: svc shows the class it would serve, 2 fast, 1 normal, 0 none
`timescale 1ns/100ps
module pic_cpu_model
   import pic_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // requests
   input wire logic fast_request,
   input wire logic normal_request,
   // service choice
   output logic [1:0] svc
);
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         svc <= 2'h0;
      end else begin
         svc <= fast_request ? 2'h2 : {1'b0, normal_request};
      end
   end
endmodule : pic_cpu_model

// ==== tb_top.sv ====
// Purpose: self-checking bench for the interrupt classifier
// Assumes: answer one edge after inputs
// Notes: slot s serves source s at 1000h plus 10h per slot
`timescale 1ns/100ps
module tb_top import pic_pkg::*;;
   typedef struct {logic [31:0] r; logic [31:0] f; logic [2:0] o; logic [31:0] a;} pic_row_t;
   logic clk, rst_b, fast_request, normal_request, vector_valid;
   logic [PIC_NSRC-1:0] req, src_en, fast_sel, fast_status, normal_status;
   logic [PIC_NSLOT-1:0] slot_en;
   logic [PIC_NSLOT*PIC_SRC_W-1:0] slot_src;
   logic [PIC_NSLOT*PIC_ADDR_W-1:0] slot_addr;
   logic [PIC_ADDR_W-1:0] default_addr, vector_addr;
   logic [1:0] svc;
   int err_count = 0;
   int cmp_count = 0;
   pic_row_t rows [7];
   pic_core pic_core_inst (.clk(clk), .rst_b(rst_b), .req(req), .src_en(src_en),
      .fast_sel(fast_sel), .slot_en(slot_en), .slot_src(slot_src), .slot_addr(slot_addr),
      .default_addr(default_addr), .fast_request(fast_request),
      .normal_request(normal_request), .fast_status(fast_status),
      .normal_status(normal_status), .vector_addr(vector_addr), .vector_valid(vector_valid));
   pic_cpu_model pic_cpu_model_inst (.clk(clk), .rst_b(rst_b), .fast_request(fast_request),
      .normal_request(normal_request), .svc(svc));
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   task automatic final_report;
      $display("counts: %0d compares, %0d mismatches", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : final_report
   task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         err_count++;
         $display("mismatch at %0t: got %h want %h", $time, got, exp);
      end
   endtask : chk_word
   task automatic apply(input logic [31:0] r, input logic [31:0] f);
      req = r;
      fast_sel = f;
      @(posedge clk);
      #1;
   endtask : apply
   initial begin
      rst_b = 1'b0;
      req = 32'hFFFFFFFF;
      fast_sel = 32'hFFFFFFFF;
      src_en = 32'hFFFFFFFF;
      slot_en = 16'hFFFF;
      default_addr = 32'h0000DEF0;
      for (int s = 0; s < PIC_NSLOT; s++) begin
         slot_src[s*PIC_SRC_W +: PIC_SRC_W] = s[4:0];
         slot_addr[s*PIC_ADDR_W +: PIC_ADDR_W] = 32'h00001000 + 32'(s * 16);
      end
      rows = '{'{32'h1, 32'h1, 3'h4, 32'hDEF0}, '{32'h6, 32'h0, 3'h3, 32'h1010},
         '{32'h80000000, 32'h0, 3'h2, 32'hDEF0}, '{32'hC000, 32'h0, 3'h3, 32'h10E0},
         '{32'h3, 32'h1, 3'h7, 32'h1010}, '{32'h80000002, 32'h0, 3'h3, 32'h1010},
         '{32'h0, 32'h0, 3'h0, 32'hDEF0}};
      repeat (5) @(posedge clk);
      #1;
      chk_word({29'h0, fast_request, normal_request, vector_valid}, 32'h0);
      rst_b = 1'b1;
      apply(32'h0, 32'h0);
      $display("test reset done");
      foreach (rows[i]) begin
         apply(rows[i].r, rows[i].f);
         chk_word({29'h0, fast_request, normal_request, vector_valid}, {29'h0, rows[i].o});
         chk_word(vector_addr, rows[i].a);
         apply(rows[i].r, rows[i].f);
         chk_word({30'h0, svc}, {30'h0, rows[i].o[2], rows[i].o[1] & ~rows[i].o[2]});
      end
      $display("test rows done");
      apply(32'h5, 32'h5);
      chk_word(fast_status, 32'h5);
      chk_word(normal_status, 32'h0);
      src_en = 32'hFFFFFFFD;
      apply(32'h2, 32'h0);
      chk_word({31'h0, normal_request}, 32'h0);
      src_en = 32'hFFFFFFFF;
      slot_en = 16'hFFFD;
      apply(32'h2, 32'h0);
      chk_word({30'h0, normal_request, vector_valid}, 32'h2);
      chk_word(normal_status, 32'h2);
      slot_en = 16'hFFFF;
      slot_src[4:0] = 5'h1F;
      apply(32'h80000002, 32'h0);
      chk_word(vector_addr, 32'h00001000);
      $display("test awkward done");
      apply(32'h3, 32'h1);
      rst_b = 1'b0;
      #2;
      chk_word({29'h0, fast_request, normal_request, vector_valid}, 32'h0);
      @(posedge clk);
      #1;
      chk_word(vector_addr, 32'h0);
      rst_b = 1'b1;
      apply(32'h1, 32'h1);
      chk_word({29'h0, fast_request, normal_request, vector_valid}, 32'h4);
      chk_word(vector_addr, 32'h0000DEF0);
      apply(32'h0, 32'h0);
      chk_word({29'h0, fast_request, normal_request, vector_valid}, 32'h0);
      $display("test midreset done");
      final_report();
   end
   initial begin
      #5000;
      err_count++;
      final_report();
   end
endmodule : tb_top
